// File: logic/sfp_cfg.svh
// Offsets, field positions, reset values and counts for the sample queue port
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH

// Queue geometry defaults
`define SFP_DEPTH_DEF 1024
`define SFP_CNT_W 16
// Identity upper bits, arbitrary neutral value
`define SFP_ID_UPPER_DEF 6'h2a

// Register offsets
`define SFP_REG_CNT_HI 8'h72
`define SFP_REG_CNT_LO 8'h73
`define SFP_REG_DATA 8'h74
`define SFP_REG_IDENT 8'h75
`define SFP_REG_SRC_EN 8'h23
`define SFP_REG_AUX 8'h24
`define SFP_REG_MASK 8'h38
`define SFP_REG_STAT 8'h3a
`define SFP_REG_CTRL 8'h6a

// Control register bits
`define SFP_CTRL_EN 6
`define SFP_CTRL_RST 2

// Source enable bits
`define SFP_EN_TEMP 7
`define SFP_EN_XG 6
`define SFP_EN_YG 5
`define SFP_EN_ZG 4
`define SFP_EN_ACCEL 3
`define SFP_EN_SLV2 2
`define SFP_EN_SLV1 1
`define SFP_EN_SLV0 0
`define SFP_AUX_SLV3 5

// Interrupt status bits
`define SFP_IRQ_OVF 4
`define SFP_IRQ_FRAME 0

// Source byte layout, index 0 is the lowest register
`define SFP_SRC_BYTES 38
`define SFP_TEMP_LO 6
`define SFP_GX_LO 8
`define SFP_GY_LO 10
`define SFP_GZ_LO 12
`define SFP_EXT_LO 14
`define SFP_EXT_BYTES 24
`define SFP_IDX_W 6
`define SFP_IDX_LAST 6'h25

// Reset values
`define SFP_RST_BYTE 8'h00
`define SFP_RST_CNT 16'h0000

`endif

// File: logic/sfp_pkg.sv
// Types shared by the sample queue port
package sfp_pkg;
	typedef logic [7:0] sfp_byte_type;
	typedef logic [7:0] sfp_addr_type;
	typedef enum {samp_idle, samp_scan} sfp_samp_type;
endpackage

// File: logic/sfp_top.sv
// Sample queue port: byte queue, count shadow, data port, identity, interrupt
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "sfp_cfg.svh"
//
// What this block does
// RQ1: Sixteen-bit byte count, read-only high/low pair
// RQ2: High byte read snapshots count into both
// RQ3: Low byte read never refreshes the snapshot
// RQ4: Host reads high byte before low byte
// RQ5: Source bytes pushed lowest register first
// RQ6: Sensor bytes pushed per set group flag
// RQ7: Slave three bytes gated by aux flag
// RQ8: Push into full queue sets overflow flag
// RQ9: Overflow drops oldest byte, keeps newest
// RQ10: Empty read repeats last popped byte
// RQ11: Host checks count before reading data
// RQ12: Data port pops on read, pushes on write
// RQ13: Identity bits 6..1 hold fixed address
// RQ14: Identity bits 0 and 7 read zero
// RQ15: Address select pin never shown in identity
// RQ16: Disabled queue neither pushes nor pops
// RQ17: Reset bit empties disabled queue, self-clears
// RQ18: Count tracks pushes and pops, saturates
//
module sfp_top #(
	parameter int DEPTH = `SFP_DEPTH_DEF,
	parameter logic [5:0] ID_UPPER = `SFP_ID_UPPER_DEF
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Register port
	input wire sfp_pkg::sfp_addr_type reg_addr_i,
	input wire sfp_pkg::sfp_byte_type reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output sfp_pkg::sfp_byte_type reg_rdata_o,
	// Sample sources
	input wire logic sample_tick_i,
	input wire logic [`SFP_SRC_BYTES*8-1:0] src_bytes_i,
	input wire logic [`SFP_EXT_BYTES*2-1:0] ext_owner_i,
	input wire logic [`SFP_EXT_BYTES-1:0] ext_valid_i,
	// Pins and interrupt
	input wire logic address_select_pin_i,
	output logic [6:0] target_addr_o,
	output logic irq_o
);
	import sfp_pkg::*;

	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [`SFP_CNT_W-1:0] DEPTH_C = `SFP_CNT_W'(DEPTH);
	localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);
	// Pointers wrap at DEPTH, so DEPTH need not be a power of two
	// Count is wider than a pointer: full and empty stay apart without a spare bit

	////////////////////////////////////////////////////////////////////////
	// State
	sfp_byte_type src_en_ff;
	sfp_byte_type aux_ctrl_ff;
	sfp_byte_type irq_mask_ff;
	sfp_byte_type irq_stat_ff;
	sfp_byte_type nxt_irq_stat;
	sfp_byte_type shadow_lo_ff;
	sfp_byte_type rdata_ff;
	sfp_byte_type last_pop_ff;
	logic fifo_en_ff;
	logic reset_req_ff;
	logic [PTR_W-1:0] rd_ptr_ff;
	logic [PTR_W-1:0] wr_ptr_ff;
	logic [PTR_W-1:0] nxt_rd_ptr;
	logic [PTR_W-1:0] nxt_wr_ptr;
	logic [`SFP_CNT_W-1:0] count_ff;
	logic [`SFP_CNT_W-1:0] nxt_count;
	sfp_byte_type mem_ff [DEPTH];
	sfp_byte_type snap_ff [`SFP_SRC_BYTES];
	sfp_samp_type samp_state_ff;
	sfp_samp_type nxt_samp_state;
	logic [`SFP_IDX_W-1:0] samp_idx_ff;
	logic [`SFP_IDX_W-1:0] nxt_samp_idx;
	logic frame_done;
	logic sel_s1_ff;
	logic sel_s2_ff;
	logic sel_s3_ff;
	logic sel_ff;
	logic irq_ff;

	////////////////////////////////////////////////////////////////////////
	// Address decode
	// Strobes qualify every decode, so an idle address has no effect
	wire rd_cnt_hi = reg_rd_i && (reg_addr_i == `SFP_REG_CNT_HI);
	wire rd_data = reg_rd_i && (reg_addr_i == `SFP_REG_DATA);
	wire rd_stat = reg_rd_i && (reg_addr_i == `SFP_REG_STAT);
	wire wr_data = reg_wr_i && (reg_addr_i == `SFP_REG_DATA);
	wire wr_src_en = reg_wr_i && (reg_addr_i == `SFP_REG_SRC_EN);
	wire wr_aux = reg_wr_i && (reg_addr_i == `SFP_REG_AUX);
	wire wr_mask = reg_wr_i && (reg_addr_i == `SFP_REG_MASK);
	wire wr_ctrl = reg_wr_i && (reg_addr_i == `SFP_REG_CTRL);

	////////////////////////////////////////////////////////////////////////
	// Queue status and transfer qualifiers
	// Host data write and pop may share a cycle; both land
	wire q_empty = (count_ff == `SFP_RST_CNT);
	wire q_full = (count_ff == DEPTH_C);
	// Reset only acts while the queue is off
	wire fifo_clear = reset_req_ff && !fifo_en_ff; // [RQ17]
	wire host_push = wr_data && fifo_en_ff && !fifo_clear; // [RQ12] [RQ16]
	wire host_pop = rd_data && fifo_en_ff && !q_empty && !fifo_clear; // [RQ10] [RQ16]
	wire [`SFP_SRC_BYTES-1:0] byte_en;
	// Host write wins the write port; sampler waits one cycle
	wire samp_push = (samp_state_ff == samp_scan) && byte_en[samp_idx_ff] && !host_push && fifo_en_ff
		&& !fifo_clear; // [RQ16]
	wire any_push = host_push || samp_push;
	wire overflow = any_push && !host_pop && q_full; // [RQ8]
	wire sfp_byte_type push_byte = host_push ? reg_wdata_i : snap_ff[samp_idx_ff];
	wire sfp_byte_type head_byte = mem_ff[rd_ptr_ff];

	////////////////////////////////////////////////////////////////////////
	// Per-byte source enables and snapshot
	wire [3:0] slave_flag = {aux_ctrl_ff[`SFP_AUX_SLV3], src_en_ff[`SFP_EN_SLV2], src_en_ff[`SFP_EN_SLV1],
		src_en_ff[`SFP_EN_SLV0]}; // [RQ7]
	genvar gi;
	generate
		for (gi = 0; gi < `SFP_SRC_BYTES; gi++) begin : g_src
			if (gi < `SFP_TEMP_LO) begin : g_acc
				assign byte_en[gi] = src_en_ff[`SFP_EN_ACCEL]; // [RQ6]
			end else if (gi < `SFP_GX_LO) begin : g_tmp
				assign byte_en[gi] = src_en_ff[`SFP_EN_TEMP]; // [RQ6]
			end else if (gi < `SFP_GY_LO) begin : g_gx
				assign byte_en[gi] = src_en_ff[`SFP_EN_XG]; // [RQ6]
			end else if (gi < `SFP_GZ_LO) begin : g_gy
				assign byte_en[gi] = src_en_ff[`SFP_EN_YG]; // [RQ6]
			end else if (gi < `SFP_EXT_LO) begin : g_gz
				assign byte_en[gi] = src_en_ff[`SFP_EN_ZG]; // [RQ6]
			end else begin : g_ext
				// External byte follows the flag of the slave owning it
				assign byte_en[gi] = ext_valid_i[gi-`SFP_EXT_LO]
					&& slave_flag[ext_owner_i[(gi-`SFP_EXT_LO)*2 +: 2]]; // [RQ6] [RQ7]
			end
			// Frame captured whole so bytes of one sample stay together
			always_ff @(posedge ref_clk_i) begin
				if ((samp_state_ff == samp_idle) && sample_tick_i) begin
					snap_ff[gi] <= src_bytes_i[gi*8 +: 8];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Sampler walks bytes in ascending register order
	// A frame takes one cycle per source byte plus one per host data write;
	// ticks arriving before the scan is back to idle are dropped, not queued
	always_comb begin
		nxt_samp_state = samp_state_ff;
		nxt_samp_idx = samp_idx_ff;
		frame_done = 1'b0;
		case (samp_state_ff)
			samp_idle: begin
				if (sample_tick_i && fifo_en_ff && !fifo_clear) begin // [RQ16]
					nxt_samp_state = samp_scan;
					nxt_samp_idx = '0;
				end
			end
			samp_scan: begin
				if (fifo_clear || !fifo_en_ff) begin
					nxt_samp_state = samp_idle;
				end else if (!host_push) begin
					if (samp_idx_ff == `SFP_IDX_LAST) begin
						nxt_samp_state = samp_idle;
						frame_done = 1'b1;
					end else begin
						nxt_samp_idx = samp_idx_ff + 1'b1; // [RQ5]
					end
				end
			end
			default: begin
				nxt_samp_state = samp_idle;
			end
		endcase
	end

	// Sampler registers
	// Index restarts at zero on every accepted tick
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			samp_state_ff <= samp_idle;
			samp_idx_ff <= '0;
		end else begin
			samp_state_ff <= nxt_samp_state;
			samp_idx_ff <= nxt_samp_idx;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pointer and count update
	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		ptr_inc = (p == LAST_PTR) ? '0 : p + 1'b1;
	endfunction

	always_comb begin
		nxt_rd_ptr = rd_ptr_ff;
		nxt_wr_ptr = wr_ptr_ff;
		nxt_count = count_ff;
		// Clear beats every transfer in the same cycle
		if (fifo_clear) begin
			nxt_rd_ptr = '0; // [RQ17]
			nxt_wr_ptr = '0;
			nxt_count = `SFP_RST_CNT;
		end else if (overflow) begin
			// Oldest byte overwritten, count held at capacity
			nxt_rd_ptr = ptr_inc(rd_ptr_ff); // [RQ9]
			nxt_wr_ptr = ptr_inc(wr_ptr_ff); // [RQ9]
			nxt_count = count_ff; // [RQ18]
		end else begin
			if (any_push) begin
				nxt_wr_ptr = ptr_inc(wr_ptr_ff);
			end
			if (host_pop) begin
				nxt_rd_ptr = ptr_inc(rd_ptr_ff);
			end
			if (any_push && !host_pop) begin
				nxt_count = count_ff + 1'b1; // [RQ18]
			end else if (host_pop && !any_push) begin
				nxt_count = count_ff - 1'b1; // [RQ18] [RQ10]
			end
		end
	end

	// Queue registers
	// Pointers and count move together from one next-state block
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			rd_ptr_ff <= '0;
			wr_ptr_ff <= '0;
			count_ff <= `SFP_RST_CNT;
		end else begin
			rd_ptr_ff <= nxt_rd_ptr;
			wr_ptr_ff <= nxt_wr_ptr;
			count_ff <= nxt_count;
		end
	end

	// Storage, no reset: contents are data only
	// Clear leaves stale bytes behind; pointers and count decide what is visible
	always_ff @(posedge ref_clk_i) begin
		if (any_push && !fifo_clear) begin
			mem_ff[wr_ptr_ff] <= push_byte; // [RQ12] [RQ9]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Software registers
	// Source and aux flags are read live by the sampler; change them between frames
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			src_en_ff <= `SFP_RST_BYTE;
			aux_ctrl_ff <= `SFP_RST_BYTE;
			irq_mask_ff <= `SFP_RST_BYTE;
		end else begin
			if (wr_src_en) begin
				src_en_ff <= reg_wdata_i; // [RQ6]
			end
			if (wr_aux) begin
				aux_ctrl_ff <= reg_wdata_i; // [RQ7]
			end
			if (wr_mask) begin
				irq_mask_ff <= reg_wdata_i;
			end
		end
	end

	// Control: enable level and self-clearing reset request
	// Enable and reset written together: enable wins, the clear is skipped
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			fifo_en_ff <= 1'b0;
			reset_req_ff <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				fifo_en_ff <= reg_wdata_i[`SFP_CTRL_EN];
			end
			reset_req_ff <= wr_ctrl && reg_wdata_i[`SFP_CTRL_RST]; // [RQ17]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mask write acts on the same edge, so a masked event never leaks out
	wire sfp_byte_type nxt_irq_mask = wr_mask ? reg_wdata_i : irq_mask_ff;

	// Interrupt status: new events beat the read clear
	always_comb begin
		nxt_irq_stat = rd_stat ? `SFP_RST_BYTE : irq_stat_ff;
		if (overflow) begin
			nxt_irq_stat[`SFP_IRQ_OVF] = 1'b1; // [RQ8]
		end
		if (frame_done) begin
			nxt_irq_stat[`SFP_IRQ_FRAME] = 1'b1;
		end
	end

	// Interrupt registers
	// Level output: high until the status read or a mask write drops it
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			irq_stat_ff <= `SFP_RST_BYTE;
			irq_ff <= 1'b0;
		end else begin
			irq_stat_ff <= nxt_irq_stat;
			irq_ff <= |(nxt_irq_stat & nxt_irq_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data selection
	// Unmapped addresses read as zero rather than aliasing a neighbour
	wire sfp_byte_type ident_byte = {1'b0, ID_UPPER, 1'b0}; // [RQ13] [RQ14] [RQ15]
	wire sfp_byte_type data_byte = host_pop ? head_byte : last_pop_ff; // [RQ10]
	wire sfp_byte_type ctrl_byte = {1'b0, fifo_en_ff, 3'h0, reset_req_ff, 2'h0};
	wire sfp_byte_type rd_mux =
		(reg_addr_i == `SFP_REG_CNT_HI) ? count_ff[15:8] : // [RQ1] [RQ2]
		(reg_addr_i == `SFP_REG_CNT_LO) ? shadow_lo_ff : // [RQ1] [RQ3]
		(reg_addr_i == `SFP_REG_DATA) ? data_byte :
		(reg_addr_i == `SFP_REG_IDENT) ? ident_byte :
		(reg_addr_i == `SFP_REG_SRC_EN) ? src_en_ff :
		(reg_addr_i == `SFP_REG_AUX) ? aux_ctrl_ff :
		(reg_addr_i == `SFP_REG_MASK) ? irq_mask_ff :
		(reg_addr_i == `SFP_REG_STAT) ? irq_stat_ff :
		(reg_addr_i == `SFP_REG_CTRL) ? ctrl_byte :
		`SFP_RST_BYTE;

	// Read data, count shadow and last popped byte
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			rdata_ff <= `SFP_RST_BYTE;
			shadow_lo_ff <= `SFP_RST_BYTE;
			last_pop_ff <= `SFP_RST_BYTE;
		end else begin
			if (reg_rd_i) begin
				rdata_ff <= rd_mux;
			end
			if (rd_cnt_hi) begin
				shadow_lo_ff <= count_ff[7:0]; // [RQ2]
			end
			if (host_pop) begin
				last_pop_ff <= head_byte; // [RQ10]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Address select pin: three stages, accepted once last two agree
	// Pin level only reaches the target address, after the filter settles
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			sel_s1_ff <= 1'b0;
			sel_s2_ff <= 1'b0;
			sel_s3_ff <= 1'b0;
			sel_ff <= 1'b0;
		end else begin
			sel_s1_ff <= address_select_pin_i;
			sel_s2_ff <= sel_s1_ff;
			sel_s3_ff <= sel_s2_ff;
			if (sel_s2_ff == sel_s3_ff) begin
				sel_ff <= sel_s3_ff;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	// Pin drives only the target address, never the identity byte
	assign target_addr_o = {ID_UPPER, sel_ff}; // [RQ15]
	// Read data and interrupt come straight from flops, no glitch to the host
	assign reg_rdata_o = rdata_ff;
	assign irq_o = irq_ff;
endmodule

// File: verif/sfp_top_properties.sv
// Checker for the sample queue port register behaviour
`timescale 1ns/1ps
`include "sfp_cfg.svh"
module sfp_checker
	import sfp_pkg::*;
#(
	parameter int DEPTH = `SFP_DEPTH_DEF,
	parameter logic [5:0] ID_UPPER = `SFP_ID_UPPER_DEF
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Register port
	input wire sfp_pkg::sfp_addr_type reg_addr_i,
	input wire sfp_pkg::sfp_byte_type reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire sfp_pkg::sfp_byte_type reg_rdata_o,
	// Pins and interrupt
	input wire logic [6:0] target_addr_o,
	input wire logic irq_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	localparam sfp_byte_type DEPTH_HI = 8'(DEPTH >> 8);
	// Access decode
	wire rd_id = reg_rd_i && reg_addr_i == `SFP_REG_IDENT;
	wire rd_hi = reg_rd_i && reg_addr_i == `SFP_REG_CNT_HI;
	wire rd_lo = reg_rd_i && reg_addr_i == `SFP_REG_CNT_LO;
	wire rd_dat = reg_rd_i && reg_addr_i == `SFP_REG_DATA;
	wire rd_ctl = reg_rd_i && reg_addr_i == `SFP_REG_CTRL;
	wire rd_st = reg_rd_i && reg_addr_i == `SFP_REG_STAT;
	wire wr_ctl = reg_wr_i && reg_addr_i == `SFP_REG_CTRL;
	wire wr_msk = reg_wr_i && reg_addr_i == `SFP_REG_MASK;
	logic en_ff, rdd_ff, rdl_ff, lo_ok_ff;
	sfp_byte_type last_ff, lo_ff;
	//////////////////////////////
	// Enable state, last data byte read, last low count read; high read wins
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			en_ff <= 1'b0;
			rdd_ff <= 1'b0;
			rdl_ff <= 1'b0;
			lo_ok_ff <= 1'b0;
			last_ff <= 8'h00;
			lo_ff <= 8'h00;
		end else begin
			if (wr_ctl) en_ff <= reg_wdata_i[`SFP_CTRL_EN];
			rdd_ff <= rd_dat;
			rdl_ff <= rd_lo;
			if (rdd_ff) last_ff <= reg_rdata_o;
			if (rdl_ff) lo_ff <= reg_rdata_o;
			lo_ok_ff <= rd_hi ? 1'b0 : (rdl_ff | lo_ok_ff);
		end
	end
	//////////////////////////////
	a_ident_fixed: assert property (rd_id |=> reg_rdata_o[6:1] == ID_UPPER)
		else $error("identity field wrong");
	a_ident_reserved: assert property (rd_id |=> !reg_rdata_o[7] && !reg_rdata_o[0])
		else $error("identity reserved bit set");
	a_pin_hidden: assert property (rd_id && target_addr_o[0] |=> reg_rdata_o[0] == 1'b0)
		else $error("pin level seen in identity");
	a_cnt_bounded: assert property (rd_hi |=> reg_rdata_o <= DEPTH_HI)
		else $error("count above capacity");
	a_lo_shadow: assert property (rd_lo && lo_ok_ff |=> reg_rdata_o == lo_ff)
		else $error("low count refreshed alone");
	a_dis_no_pop: assert property (rd_dat && !en_ff |=> reg_rdata_o == last_ff)
		else $error("disabled read popped");
	a_clr_self: assert property (wr_ctl && reg_wdata_i[`SFP_CTRL_RST] ##2 rd_ctl |=> !reg_rdata_o[2])
		else $error("clear bit stuck");
	a_mask_quiet: assert property (wr_msk && reg_wdata_i == 8'h00 |=> !irq_o)
		else $error("masked interrupt raised");
	a_read_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved without read");
	// Main scenarios
	c_overflow: cover property (rd_st ##1 reg_rdata_o[`SFP_IRQ_OVF]);
	c_frame: cover property (rd_st ##1 reg_rdata_o[`SFP_IRQ_FRAME]);
	c_irq: cover property ($rose(irq_o));
endmodule
bind sfp_top sfp_checker #(.DEPTH(DEPTH), .ID_UPPER(ID_UPPER)) u_chk (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .target_addr_o(target_addr_o), .irq_o(irq_o));

// File: verif/sfp_host_model.sv
// Host model: register bus master of the sample queue port
`timescale 1ns/1ps
`include "sfp_cfg.svh"
module sfp_host_model
	import sfp_pkg::*;
(
	// Clock
	input wire logic ref_clk_i,
	// Register bus
	output sfp_pkg::sfp_addr_type reg_addr_o,
	output sfp_pkg::sfp_byte_type reg_wdata_o,
	output logic reg_wr_o,
	output logic reg_rd_o
);
	// Quiet bus at time zero
	initial begin
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
	end
	//////////////////////////////
	// One-cycle strobes; the slave never stalls
	task automatic wr(input sfp_addr_type a, input sfp_byte_type d);
		@(posedge ref_clk_i);
		reg_addr_o <= a;
		reg_wdata_o <= d;
		reg_wr_o <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_o <= 1'b0;
	endtask
	task automatic rd(input sfp_addr_type a);
		@(posedge ref_clk_i);
		reg_addr_o <= a;
		reg_rd_o <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd_o <= 1'b0;
	endtask
	// High first, else the low byte is a stale snapshot
	task automatic rd_count();
		rd(`SFP_REG_CNT_HI);
		rd(`SFP_REG_CNT_LO);
	endtask
endmodule

// File: verif/sensor_fifo_port_tb_top.sv
// Testbench: host traffic, overflow, shadowed count and sampled frames
`timescale 1ns/1ps
`include "sfp_cfg.svh"
module sensor_fifo_port_tb_top;
	import sfp_pkg::*;
	localparam int DEPTH = 8;
	localparam logic [5:0] ID_UP = 6'h15; // Arbitrary identity value
	logic clk, rst, wr, rd, tick, pin, irq;
	logic rd_ff = 1'b0;
	sfp_addr_type addr;
	sfp_byte_type wdata, rdata, lf, last;
	logic [6:0] taddr;
	logic [303:0] src;
	logic [47:0] owner;
	logic [23:0] valid;
	int num_errors = 0, n_checks = 0, cyc = 0, npush = 0;
	sfp_byte_type exp_q[$], m[$];
	sfp_top #(.DEPTH(DEPTH), .ID_UPPER(ID_UP)) u_dut (.ref_clk_i(clk), .reset_i(rst), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .sample_tick_i(tick),
		.src_bytes_i(src), .ext_owner_i(owner), .ext_valid_i(valid), .address_select_pin_i(pin),
		.target_addr_o(taddr), .irq_o(irq));
	sfp_host_model u_host (.ref_clk_i(clk), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	//////////////////////////////
	function automatic sfp_byte_type nxt(input sfp_byte_type s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic check(input sfp_byte_type seen, input sfp_byte_type exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d, errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Note the expected byte, then read
	task automatic rdx(input sfp_addr_type a, input sfp_byte_type e);
		exp_q.push_back(e);
		u_host.rd(a);
	endtask
	task automatic cnt(input logic [15:0] e);
		exp_q.push_back(e[15:8]);
		exp_q.push_back(e[7:0]);
		u_host.rd_count();
	endtask
	// Queue model keeps only the newest DEPTH bytes
	task automatic push(input sfp_byte_type v);
		m.push_back(v);
		if (m.size() > DEPTH) void'(m.pop_front());
	endtask
	task automatic wrd();
		lf = nxt(lf);
		push(lf);
		u_host.wr(`SFP_REG_DATA, lf);
	endtask
	task automatic drain();
		while (m.size() > 0) begin
			last = m.pop_front();
			rdx(`SFP_REG_DATA, last);
		end
	endtask
	// Expected push of source byte k, from its group flag or its owner's slave flag
	function automatic logic en_of(input int k, input sfp_byte_type e, input logic aux);
		logic [3:0] f;
		f = {aux, e[`SFP_EN_SLV2:`SFP_EN_SLV0]};
		if (k < 6) return e[`SFP_EN_ACCEL];
		if (k < 8) return e[`SFP_EN_TEMP];
		if (k < 14) return e[`SFP_EN_XG - (k - 8) / 2];
		return valid[k - 14] && f[owner[2 * (k - 14) +: 2]];
	endfunction
	// One sample: random frame, owners and valid flags; then count, status and every byte
	task automatic scan_test(input sfp_byte_type e, input logic aux);
		npush = 0;
		for (int k = 0; k < 38; k++) begin
			lf = nxt(lf);
			src[8*k+:8] <= lf;
			if (k < 24) begin
				owner[2*k+:2] <= lf[4:3];
				valid[k] <= lf[5] | lf[6];
			end
		end
		u_host.wr(`SFP_REG_SRC_EN, e);
		u_host.wr(`SFP_REG_AUX, aux ? 8'h20 : 8'h00);
		for (int k = 0; k < 38; k++) begin
			if (en_of(k, e, aux)) begin
				push(src[8*k+:8]);
				npush++;
			end
		end
		tick <= 1'b1;
		@(posedge clk);
		tick <= 1'b0;
		repeat (45) @(posedge clk);
		cnt(16'(m.size()));
		rdx(`SFP_REG_STAT, (npush > DEPTH) ? 8'h11 : 8'h01);
		drain();
	endtask
	//////////////////////////////
	// Read monitor and run limit
	always @(posedge clk) begin
		cyc++;
		if (rd_ff) check(rdata, exp_q.pop_front());
		rd_ff <= rd;
		if (cyc == 2000) begin
			num_errors++;
			end_of_test();
		end
	end
	initial begin
		rst = 1'b1;
		tick = 1'b0;
		pin = 1'b1;
		src = '0;
		owner = '1;
		valid = '1;
		lf = 8'h3f;
		last = 8'h00;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		check({1'b0, taddr}, {1'b0, ID_UP, 1'b1});
		rdx(`SFP_REG_IDENT, {1'b0, ID_UP, 1'b0});
		pin <= 1'b0;
		rdx(`SFP_REG_IDENT, {1'b0, ID_UP, 1'b0});
		rdx(8'h00, 8'h00);
		$display("identity test done");
		u_host.wr(`SFP_REG_MASK, 8'h10);
		u_host.wr(`SFP_REG_CTRL, 8'h40);
		repeat (DEPTH + 2) wrd();
		repeat (2) @(posedge clk);
		check({7'h00, irq}, 8'h01);
		u_host.wr(`SFP_REG_MASK, 8'h00);
		@(posedge clk);
		check({7'h00, irq}, 8'h00);
		u_host.wr(`SFP_REG_MASK, 8'h10);
		@(posedge clk);
		check({7'h00, irq}, 8'h01);
		cnt(16'(DEPTH));
		rdx(`SFP_REG_STAT, 8'h10);
		repeat (3) @(posedge clk);
		check({7'h00, irq}, 8'h00);
		drain();
		repeat (2) rdx(`SFP_REG_DATA, last);
		cnt(16'h0000);
		repeat (3) wrd();
		rdx(`SFP_REG_CNT_LO, 8'h00);
		cnt(16'h0003);
		$display("overflow and count test done");
		u_host.wr(`SFP_REG_CTRL, 8'h00);
		u_host.wr(`SFP_REG_DATA, 8'hee);
		rdx(`SFP_REG_DATA, last);
		cnt(16'h0003);
		u_host.wr(`SFP_REG_CTRL, 8'h04);
		rdx(`SFP_REG_CTRL, 8'h00);
		u_host.wr(`SFP_REG_CTRL, 8'h40);
		cnt(16'h0000);
		m.delete();
		$display("disable test done");
		u_host.wr(`SFP_REG_MASK, 8'h00);
		scan_test(8'h48, 1'b0);
		scan_test(8'hb0, 1'b0);
		scan_test(8'h05, 1'b1);
		$display("sampler test done");
		repeat (2) @(posedge clk);
		check(8'(exp_q.size()), 8'h00);
		end_of_test();
	end
endmodule
